// >>> src/pad_ctl.sv
// Pad state controller: per pin output, output enable, pull-up and input
// gating chosen from the pin function and the CPU state.
// Assumes cpu_state, osc_running and the peripheral and USB drives come
// from logic on clk_sys; pad inputs come from pins and are synchronised.
// Notes on behaviour
// - Blocked input: tri-state, no pull-up, input 0
// - Open input: tri-state, no pull-up, pin passes
// - Pull-programmable: tri-state, pull-up from register, open
// - Clock input blocked unless oscillator runs
// - Live control: GPIO registers or peripheral drive output, register drives pull-up
// - Pull-free control: peripheral drives output, pull-up off
// - Hold open: frozen drives, input open
// - Hold blocked: frozen drives, input blocked
// - Copy hold: GPIO settings captured, input blocked
// - USB pins owned in run, tri-stated otherwise
// - Stop modes: hold or block by pin level
// - Deep standby: GPIO hold-blocked, peripheral and interrupt functions copy-hold, or block by level
// - After wake, hold while release bit is 1
// - Power-on reset blocks; pin reset opens input
// - Reset pin: input, pull-up on, never blocked
// - Boot pin: input, no pull-up, never blocked
// - Pin reset sets debug pull-up bit to 1
// - Oscillator pins tri-stated, no pull-up, input 0
// - Analog pins: digital side blocked, analog active
// - Wake-up pins pull-programmable from run onward
// - Interrupt pins pull-programmable, deep copy-hold or blocked
// - Wake-up-0 pin pull-programmable from run onward
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module pad_ctl #(
   parameter int PIN_COUNT = 8   // At most 8 pins fit one register word
) (
   // Clock, reset and enable
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   // Avalon-MM slave
   input wire logic [pad_ctl_pkg::ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // System state
   input wire pad_ctl_pkg::cpu_state_t cpu_state,
   input wire logic osc_running,
   // Peripheral and USB drive requests
   input wire logic [PIN_COUNT-1:0] periph_out,
   input wire logic [PIN_COUNT-1:0] periph_oe,
   input wire logic [PIN_COUNT-1:0] usb_out,
   input wire logic [PIN_COUNT-1:0] usb_oe,
   // Pads
   input wire logic [PIN_COUNT-1:0] pad_in,
   output logic [PIN_COUNT-1:0] pad_out,
   output logic [PIN_COUNT-1:0] pad_oe,
   output logic [PIN_COUNT-1:0] pad_pullup,
   output logic [PIN_COUNT-1:0] analog_en,
   // Internal input values
   output logic [PIN_COUNT-1:0] pin_value,
   // Dedicated reset and boot pins
   input wire logic external_reset_pin,
   input wire logic boot_mode_pin,
   output logic external_reset_level,
   output logic external_reset_pullup,
   output logic boot_mode_level,
   output logic boot_mode_pullup
);

   // Merge write data into a word under byte enables
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                               input logic [31:0] new_val,
                                               input logic [3:0] be);
      logic [31:0] res;
      res = old_val;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = new_val[b*8 +: 8];
         end
      end
      return res;
   endfunction : merge_bytes

   // Pad state from pin function, CPU state and standby controls
   function automatic pad_ctl_pkg::pad_state_t pick_state(input logic [3:0] fn,
         input pad_ctl_pkg::cpu_state_t cs, input logic standby_pin_level, input logic hold_rel);
      pad_ctl_pkg::pad_state_t st;
      st = pad_ctl_pkg::blocked_input_state;
      unique case (cs)
         pad_ctl_pkg::CPU_POR_RESET: st = pad_ctl_pkg::blocked_input_state;
         pad_ctl_pkg::CPU_PIN_RESET: begin
            st = (fn == pad_ctl_pkg::FN_DEBUG) ? pad_ctl_pkg::pull_programmable_state
                                               : pad_ctl_pkg::open_input_state;
         end
         default: begin
            unique case (fn)
               pad_ctl_pkg::FN_OSC, pad_ctl_pkg::FN_ANALOG: begin
                  st = pad_ctl_pkg::blocked_input_state;
               end
               pad_ctl_pkg::FN_CLK_EXT: begin
                  st = (cs == pad_ctl_pkg::CPU_RUN || cs == pad_ctl_pkg::CPU_STOP)
                     ? pad_ctl_pkg::clock_input_state : pad_ctl_pkg::blocked_input_state;
               end
               pad_ctl_pkg::FN_USB: begin
                  st = (cs == pad_ctl_pkg::CPU_RUN) ? pad_ctl_pkg::usb_owned_state
                                                    : pad_ctl_pkg::usb_off_state;
               end
               pad_ctl_pkg::FN_PULL_FREE: st = pad_ctl_pkg::pull_free_control_state;
               pad_ctl_pkg::FN_DEBUG: begin
                  st = (cs == pad_ctl_pkg::CPU_RUN) ? pad_ctl_pkg::live_control_state
                                                    : pad_ctl_pkg::pull_programmable_state;
               end
               pad_ctl_pkg::FN_WAKEUP, pad_ctl_pkg::FN_WAKEUP_ZERO: begin
                  st = pad_ctl_pkg::pull_programmable_state;
               end
               pad_ctl_pkg::FN_EXT_INT: begin
                  if (cs == pad_ctl_pkg::CPU_DEEP) begin
                     st = standby_pin_level ? pad_ctl_pkg::blocked_input_state
                              : pad_ctl_pkg::copy_hold_state;
                  end else if (cs == pad_ctl_pkg::CPU_WAKE && hold_rel) begin
                     st = pad_ctl_pkg::copy_hold_state;
                  end else begin
                     st = pad_ctl_pkg::pull_programmable_state;
                  end
               end
               default: begin
                  // GPIO and other peripheral functions
                  if (cs == pad_ctl_pkg::CPU_RUN ||
                      (cs == pad_ctl_pkg::CPU_WAKE && !hold_rel)) begin
                     st = pad_ctl_pkg::live_control_state;
                  end else if (cs == pad_ctl_pkg::CPU_STOP) begin
                     st = standby_pin_level ? pad_ctl_pkg::blocked_input_state
                              : pad_ctl_pkg::hold_open_state;
                  end else if (cs == pad_ctl_pkg::CPU_DEEP && standby_pin_level) begin
                     st = pad_ctl_pkg::blocked_input_state;
                  end else if (fn == pad_ctl_pkg::FN_GPIO) begin
                     st = pad_ctl_pkg::hold_blocked_state;
                  end else begin
                     st = pad_ctl_pkg::copy_hold_state;
                  end
               end
            endcase
         end
      endcase
      return st;
   endfunction : pick_state

   // Software registers
   logic [31:0] func_sel_reg;
   logic [PIN_COUNT-1:0] gpio_out_reg;
   logic [PIN_COUNT-1:0] gpio_oe_reg;
   logic [PIN_COUNT-1:0] pullup_reg;
   logic [PIN_COUNT-1:0] pullup_next;
   logic standby_pin_level_reg;
   logic io_hold_release_reg;
   logic io_hold_release_next;
   // Bus answer flops
   logic waitrequest_reg;
   logic [31:0] readdata_reg;
   // Previous CPU state and low-power latches
   pad_ctl_pkg::cpu_state_t prev_state_reg;
   logic [PIN_COUNT-1:0] hold_out_reg;
   logic [PIN_COUNT-1:0] hold_oe_reg;
   logic [PIN_COUNT-1:0] hold_pu_reg;
   logic [PIN_COUNT-1:0] copy_out_reg;
   logic [PIN_COUNT-1:0] copy_oe_reg;
   logic [PIN_COUNT-1:0] copy_pu_reg;
   // Pin synchronisers
   logic [PIN_COUNT-1:0] pad_meta_reg;
   logic [PIN_COUNT-1:0] pad_sync_reg;
   logic [1:0] ded_meta_reg;
   logic [1:0] ded_sync_reg;
   // Pad output flops
   logic [PIN_COUNT-1:0] pad_out_reg;
   logic [PIN_COUNT-1:0] pad_oe_reg;
   logic [PIN_COUNT-1:0] pad_pullup_reg;
   logic [PIN_COUNT-1:0] analog_en_reg;
   logic [PIN_COUNT-1:0] pin_value_reg;
   logic external_reset_level_reg;
   logic boot_mode_level_reg;
   // Combinational pad values
   logic [PIN_COUNT-1:0] pad_out_next;
   logic [PIN_COUNT-1:0] pad_oe_next;
   logic [PIN_COUNT-1:0] pad_pullup_next;
   logic [PIN_COUNT-1:0] pin_value_next;
   logic [PIN_COUNT-1:0] analog_en_next;
   logic [PIN_COUNT-1:0] live_out;
   logic [PIN_COUNT-1:0] live_oe;

   // Bus decode
   wire logic bus_req = read || write;
   wire logic wr_take = ce && write && !waitrequest_reg;
   wire logic wr_func = wr_take && address == pad_ctl_pkg::OFS_FUNC_SEL;
   wire logic wr_out = wr_take && address == pad_ctl_pkg::OFS_GPIO_OUT;
   wire logic wr_oe = wr_take && address == pad_ctl_pkg::OFS_GPIO_OE;
   wire logic wr_pu = wr_take && address == pad_ctl_pkg::OFS_PULLUP_CONTROL;
   wire logic wr_stb = wr_take && address == pad_ctl_pkg::OFS_STANDBY_MODE_CONTROL;
   wire logic [31:0] stb_word = {30'h0000_0000, io_hold_release_reg, standby_pin_level_reg};
   wire logic [31:0] stb_merged = merge_bytes(stb_word, writedata, byteenable);
   wire logic [31:0] rd_mux =
      (address == pad_ctl_pkg::OFS_FUNC_SEL) ? func_sel_reg :
      (address == pad_ctl_pkg::OFS_GPIO_OUT) ? 32'(gpio_out_reg) :
      (address == pad_ctl_pkg::OFS_GPIO_OE) ? 32'(gpio_oe_reg) :
      (address == pad_ctl_pkg::OFS_PULLUP_CONTROL) ? 32'(pullup_reg) :
      (address == pad_ctl_pkg::OFS_STANDBY_MODE_CONTROL) ? stb_word :
      (address == pad_ctl_pkg::OFS_PIN_INPUT) ? 32'(pin_value_reg) :
      (address == pad_ctl_pkg::OFS_CPU_STATUS) ? 32'(prev_state_reg) : 32'h0000_0000;

   // Low-power entry from run, and which states are low power
   wire logic is_low_power = cpu_state == pad_ctl_pkg::CPU_STOP ||
                             cpu_state == pad_ctl_pkg::CPU_DEEP;
   wire logic lp_entry = is_low_power && prev_state_reg == pad_ctl_pkg::CPU_RUN;
   wire logic pin_reset = cpu_state == pad_ctl_pkg::CPU_PIN_RESET;

   // Per pin: live drives, pad state and resulting pad values
   always_comb begin
      pad_ctl_pkg::pad_state_t st;
      logic [3:0] fn;
      logic hout;
      logic hoe;
      logic hpu;
      st = pad_ctl_pkg::blocked_input_state;
      fn = 4'h0;
      hout = 1'b0;
      hoe = 1'b0;
      hpu = 1'b0;
      pullup_next = pullup_reg;
      for (int i = 0; i < PIN_COUNT; i++) begin
         fn = func_sel_reg[i*pad_ctl_pkg::FUNC_W +: pad_ctl_pkg::FUNC_W];
         // GPIO drives from registers, others from the peripheral
         live_out[i] = (fn == pad_ctl_pkg::FN_GPIO) ? gpio_out_reg[i] : periph_out[i];
         live_oe[i] = (fn == pad_ctl_pkg::FN_GPIO) ? gpio_oe_reg[i] : periph_oe[i];
         st = pick_state(fn, cpu_state, standby_pin_level_reg, io_hold_release_reg);
         // On the entry edge the latch is still loading, so use live values
         hout = lp_entry ? live_out[i] : hold_out_reg[i];
         hoe = lp_entry ? live_oe[i] : hold_oe_reg[i];
         hpu = lp_entry ? pullup_reg[i] : hold_pu_reg[i];
         pad_out_next[i] = 1'b0;
         pad_oe_next[i] = 1'b0;
         pad_pullup_next[i] = 1'b0;
         pin_value_next[i] = pad_sync_reg[i];
         analog_en_next[i] = fn == pad_ctl_pkg::FN_ANALOG;
         unique case (st)
            pad_ctl_pkg::blocked_input_state: pin_value_next[i] = 1'b0;
            pad_ctl_pkg::open_input_state: pin_value_next[i] = pad_sync_reg[i];
            pad_ctl_pkg::pull_programmable_state: pad_pullup_next[i] = pullup_reg[i];
            pad_ctl_pkg::clock_input_state: begin
               pin_value_next[i] = osc_running && pad_sync_reg[i];
            end
            pad_ctl_pkg::live_control_state: begin
               pad_out_next[i] = live_out[i];
               pad_oe_next[i] = live_oe[i];
               pad_pullup_next[i] = pullup_reg[i];
            end
            pad_ctl_pkg::pull_free_control_state: begin
               pad_out_next[i] = live_out[i];
               pad_oe_next[i] = live_oe[i];
            end
            pad_ctl_pkg::hold_open_state: begin
               pad_out_next[i] = hout;
               pad_oe_next[i] = hoe;
               pad_pullup_next[i] = hpu;
            end
            pad_ctl_pkg::hold_blocked_state: begin
               pad_out_next[i] = hout;
               pad_oe_next[i] = hoe;
               pad_pullup_next[i] = hpu;
               pin_value_next[i] = 1'b0;
            end
            pad_ctl_pkg::copy_hold_state: begin
               pad_out_next[i] = lp_entry ? gpio_out_reg[i] : copy_out_reg[i];
               pad_oe_next[i] = lp_entry ? gpio_oe_reg[i] : copy_oe_reg[i];
               pad_pullup_next[i] = lp_entry ? pullup_reg[i] : copy_pu_reg[i];
               pin_value_next[i] = 1'b0;
            end
            pad_ctl_pkg::usb_owned_state: begin
               pad_out_next[i] = usb_out[i];
               pad_oe_next[i] = usb_oe[i];
            end
            pad_ctl_pkg::usb_off_state: pin_value_next[i] = 1'b0;
         endcase
         // Pin reset puts the debug pin pull-up bit at 1
         if (pin_reset && fn == pad_ctl_pkg::FN_DEBUG) begin
            pullup_next[i] = 1'b1;
         end else if (wr_pu && byteenable[0]) begin
            pullup_next[i] = writedata[i];
         end
      end
   end

   // Hardware sets the hold bit in every deep standby cycle; the set beats a write of 0
   always_comb begin
      io_hold_release_next = io_hold_release_reg;
      if (wr_stb) begin
         io_hold_release_next = stb_merged[pad_ctl_pkg::BIT_IO_HOLD_RELEASE];
      end
      if (cpu_state == pad_ctl_pkg::CPU_DEEP) begin
         io_hold_release_next = 1'b1;
      end
   end

   // Bus slave: one wait cycle, then a one-cycle answer
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         waitrequest_reg <= 1'b1;
         readdata_reg <= pad_ctl_pkg::RST_ZERO;
      end else if (ce) begin
         waitrequest_reg <= !(bus_req && waitrequest_reg);
         readdata_reg <= rd_mux;
      end
   end

   // Software registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         func_sel_reg <= pad_ctl_pkg::RST_FUNC_SEL;
         gpio_out_reg <= '0;
         gpio_oe_reg <= '0;
         pullup_reg <= '0;
         standby_pin_level_reg <= pad_ctl_pkg::RST_STANDBY_PIN_LEVEL;
         io_hold_release_reg <= pad_ctl_pkg::RST_IO_HOLD_RELEASE;
      end else if (ce) begin
         if (wr_func) begin
            func_sel_reg <= merge_bytes(func_sel_reg, writedata, byteenable);
         end
         if (wr_out && byteenable[0]) begin
            gpio_out_reg <= writedata[PIN_COUNT-1:0];
         end
         if (wr_oe && byteenable[0]) begin
            gpio_oe_reg <= writedata[PIN_COUNT-1:0];
         end
         if (wr_stb) begin
            standby_pin_level_reg <= stb_merged[pad_ctl_pkg::BIT_STANDBY_PIN_LEVEL];
         end
         pullup_reg <= pullup_next;
         io_hold_release_reg <= io_hold_release_next;
      end
   end

   // Latch drives and GPIO settings on entry to low power
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prev_state_reg <= pad_ctl_pkg::CPU_POR_RESET;
         hold_out_reg <= '0;
         hold_oe_reg <= '0;
         hold_pu_reg <= '0;
         copy_out_reg <= '0;
         copy_oe_reg <= '0;
         copy_pu_reg <= '0;
      end else if (ce) begin
         prev_state_reg <= cpu_state;
         if (lp_entry) begin
            hold_out_reg <= live_out;
            hold_oe_reg <= live_oe;
            hold_pu_reg <= pullup_reg;
            copy_out_reg <= gpio_out_reg;
            copy_oe_reg <= gpio_oe_reg;
            copy_pu_reg <= pullup_reg;
         end
      end
   end

   // Pin synchronisers and registered pad outputs
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pad_meta_reg <= '0;
         pad_sync_reg <= '0;
         ded_meta_reg <= 2'h0;
         ded_sync_reg <= 2'h0;
         pad_out_reg <= '0;
         pad_oe_reg <= '0;
         pad_pullup_reg <= '0;
         analog_en_reg <= '0;
         pin_value_reg <= '0;
         external_reset_level_reg <= 1'b1;
         boot_mode_level_reg <= 1'b0;
      end else if (ce) begin
         pad_meta_reg <= pad_in;
         pad_sync_reg <= pad_meta_reg;
         ded_meta_reg <= {boot_mode_pin, external_reset_pin};
         ded_sync_reg <= ded_meta_reg;
         pad_out_reg <= pad_out_next;
         pad_oe_reg <= pad_oe_next;
         pad_pullup_reg <= pad_pullup_next;
         analog_en_reg <= analog_en_next;
         pin_value_reg <= pin_value_next;
         external_reset_level_reg <= ded_sync_reg[0];
         boot_mode_level_reg <= ded_sync_reg[1];
      end
   end

   // Outputs
   assign readdata = readdata_reg;
   assign waitrequest = waitrequest_reg;
   assign pad_out = pad_out_reg;
   assign pad_oe = pad_oe_reg;
   assign pad_pullup = pad_pullup_reg;
   assign analog_en = analog_en_reg;
   assign pin_value = pin_value_reg;
   assign external_reset_level = external_reset_level_reg;
   assign boot_mode_level = boot_mode_level_reg;
   assign external_reset_pullup = 1'b1;
   assign boot_mode_pullup = 1'b0;

   // Checks on the bus answer
   bus_answer_a: assert property (@(posedge clk_sys) disable iff (rst)
      ce && bus_req && waitrequest |=> !waitrequest)
      else $error("bus request not answered next cycle");
   answer_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
      ce && !waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");

   // Checks per pin
   for (genvar g = 0; g < PIN_COUNT; g++) begin : gen_chk
      wire logic [3:0] fn_g = func_sel_reg[g*pad_ctl_pkg::FUNC_W +: pad_ctl_pkg::FUNC_W];
      analog_block_a: assert property (@(posedge clk_sys) disable iff (rst)
         ce && fn_g == pad_ctl_pkg::FN_ANALOG |=> !pad_oe[g] && !pad_pullup[g]
         && !pin_value[g] && analog_en[g])
         else $error("analog pin digital side not blocked");
      usb_off_a: assert property (@(posedge clk_sys) disable iff (rst)
         ce && fn_g == pad_ctl_pkg::FN_USB && is_low_power |=> !pad_oe[g] && !pin_value[g])
         else $error("usb pin driven in low power");
      stop_block_a: assert property (@(posedge clk_sys) disable iff (rst)
         ce && fn_g == pad_ctl_pkg::FN_GPIO && cpu_state == pad_ctl_pkg::CPU_STOP
         && standby_pin_level_reg |=> !pad_oe[g] && !pad_pullup[g] && !pin_value[g])
         else $error("stop mode pin not blocked");
      hold_stable_a: assert property (@(posedge clk_sys) disable iff (rst)
         (ce && fn_g == pad_ctl_pkg::FN_GPIO && cpu_state == pad_ctl_pkg::CPU_STOP
         && !standby_pin_level_reg)[*2] |=> $stable(pad_out[g]) && $stable(pad_oe[g]))
         else $error("held pad drive changed");
      debug_pullup_a: assert property (@(posedge clk_sys) disable iff (rst)
         ce && pin_reset && fn_g == pad_ctl_pkg::FN_DEBUG |=> pullup_reg[g] ##1
         (!ce || pad_pullup[g] || cpu_state != pad_ctl_pkg::CPU_PIN_RESET
         || $past(cpu_state) != pad_ctl_pkg::CPU_PIN_RESET))
         else $error("debug pull-up not set by pin reset");
      wake_open_a: assert property (@(posedge clk_sys) disable iff (rst)
         ce && fn_g == pad_ctl_pkg::FN_WAKEUP && cpu_state == pad_ctl_pkg::CPU_DEEP
         |=> !pad_oe[g] && pin_value[g] == $past(pad_sync_reg[g]))
         else $error("wake-up pin input blocked");
   end : gen_chk

   // Dedicated pins never lose their pull-up setting
   reset_pullup_a: assert property (@(posedge clk_sys) disable iff (rst)
      external_reset_pullup && !boot_mode_pullup)
      else $error("dedicated pin pull-up wrong");

endmodule : pad_ctl

// >>> src/pad_ctl_pkg.sv
// Package for the pad state controller: CPU states, pad states, pin
// functions, register offsets and reset values.
// Assumes the power controller encodes the CPU state with cpu_state_t.
package pad_ctl_pkg;

   // CPU state as reported by the power controller
   typedef enum logic [2:0] {
      CPU_POR_RESET,   // Power-on or low-voltage reset
      CPU_PIN_RESET,   // External pin reset or post power-on init
      CPU_RUN,         // Run or sleep
      CPU_STOP,        // Timer, RTC or stop mode
      CPU_DEEP,        // Deep standby stop or RTC
      CPU_WAKE         // Run after deep standby wake-up
   } cpu_state_t;

   // Pad state per pin
   typedef enum logic [3:0] {
      blocked_input_state,
      open_input_state,
      pull_programmable_state,
      clock_input_state,
      live_control_state,
      pull_free_control_state,
      hold_open_state,
      hold_blocked_state,
      copy_hold_state,
      usb_owned_state,
      usb_off_state
   } pad_state_t;

   // Pin function codes, four bits per pin in the function register
   localparam int FUNC_W = 4;
   localparam logic [3:0] FN_GPIO = 4'h0;
   localparam logic [3:0] FN_PERIPH = 4'h1;
   localparam logic [3:0] FN_PULL_FREE = 4'h2;
   localparam logic [3:0] FN_OSC = 4'h3;
   localparam logic [3:0] FN_CLK_EXT = 4'h4;
   localparam logic [3:0] FN_USB = 4'h5;
   localparam logic [3:0] FN_DEBUG = 4'h6;
   localparam logic [3:0] FN_ANALOG = 4'h7;
   localparam logic [3:0] FN_WAKEUP = 4'h8;
   localparam logic [3:0] FN_WAKEUP_ZERO = 4'h9;
   localparam logic [3:0] FN_EXT_INT = 4'hA;

   // Register byte offsets
   localparam int ADDR_W = 5;
   localparam logic [4:0] OFS_FUNC_SEL = 5'h00;
   localparam logic [4:0] OFS_GPIO_OUT = 5'h04;
   localparam logic [4:0] OFS_GPIO_OE = 5'h08;
   localparam logic [4:0] OFS_PULLUP_CONTROL = 5'h0C;
   localparam logic [4:0] OFS_STANDBY_MODE_CONTROL = 5'h10;
   localparam logic [4:0] OFS_PIN_INPUT = 5'h14;
   localparam logic [4:0] OFS_CPU_STATUS = 5'h18;

   // Field positions in the standby mode control register
   localparam int BIT_STANDBY_PIN_LEVEL = 0;
   localparam int BIT_IO_HOLD_RELEASE = 1;

   // Reset values
   localparam logic [31:0] RST_FUNC_SEL = 32'h0000_0000;
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic RST_STANDBY_PIN_LEVEL = 1'b0;
   localparam logic RST_IO_HOLD_RELEASE = 1'b1;

endpackage : pad_ctl_pkg

// >>> test/pad_ctl_tb.sv
// Self-checking bench for the pad state controller.
// Assumes pad_ctl and pad_ctl_pkg are compiled first; one 20 MHz clock.
`timescale 1ns/1ps
module pad_ctl_tb;
   // Design inputs
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic read = 1'b0;
   logic write = 1'b0;
   logic osc_running = 1'b0;
   logic [4:0] address = 5'h00;
   logic [31:0] writedata = 32'h0000_0000;
   logic [7:0] periph_out = 8'h00;
   logic [7:0] pad_in = 8'h00;
   logic [7:0] usb_out = 8'h00;
   logic [7:0] usb_oe = 8'h00;
   logic ext_rst_pin = 1'b1;
   logic boot_pin = 1'b0;
   pad_ctl_pkg::cpu_state_t cpu_state = pad_ctl_pkg::CPU_POR_RESET;
   // Design outputs
   logic [31:0] readdata;
   logic waitrequest;
   logic [7:0] pad_out, pad_oe, pad_pullup, analog_en, pin_value;
   logic erl, erp, bml, bmp;
   // Bench bookkeeping
   logic [31:0] rd, r;
   int failures = 0;
   int n_checks = 0;
   int cycles = 0;
   integer seed = 32'haa63b3f8;

   pad_ctl pad_ctl_i (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
      .waitrequest(waitrequest), .cpu_state(cpu_state), .osc_running(osc_running),
      .periph_out(periph_out), .periph_oe(periph_out), .usb_out(usb_out), .usb_oe(usb_oe),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
      .analog_en(analog_en), .pin_value(pin_value), .external_reset_pin(ext_rst_pin),
      .boot_mode_pin(boot_pin), .external_reset_level(erl), .external_reset_pullup(erp),
      .boot_mode_level(bml), .boot_mode_pullup(bmp));

   // Clock and hang guard
   initial forever #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         close_out();
      end
   end

   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check

   // One Avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      @(posedge clk_sys);
      while (waitrequest !== 1'b0) @(posedge clk_sys);
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge clk_sys);
   endtask : bus

   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : settle

   // Same function code in every pin field
   function automatic logic [31:0] fill(input logic [3:0] code);
      return {8{code}};
   endfunction : fill

   task automatic close_out();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : close_out

   // Main sequence
   initial begin
      settle(12);
      rst <= 1'b0;
      pad_in <= 8'hFF;
      settle(5);
      check(pin_value, 32'h0000_0000);
      check({pad_oe, pad_pullup}, 32'h0000_0000);
      cpu_state <= pad_ctl_pkg::CPU_PIN_RESET;
      settle(5);
      check(pin_value, 32'h0000_00FF);
      check(pad_oe, 32'h0000_0000);
      bus(1'b0, 5'h1C, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      bus(1'b0, pad_ctl_pkg::OFS_STANDBY_MODE_CONTROL, 32'h0000_0000);
      check(rd, 32'h0000_0002);
      check({erp, bmp}, 32'h0000_0002);
      $display("test reset done");
      cpu_state <= pad_ctl_pkg::CPU_RUN;
      r = $random(seed);
      periph_out <= r[31:24];
      bus(1'b1, pad_ctl_pkg::OFS_GPIO_OUT, r);
      bus(1'b1, pad_ctl_pkg::OFS_GPIO_OE, r >> 8);
      bus(1'b1, pad_ctl_pkg::OFS_PULLUP_CONTROL, r >> 16);
      settle(2);
      check({pad_pullup, pad_oe, pad_out}, r[23:0]);
      cpu_state <= pad_ctl_pkg::CPU_STOP;
      settle(2);
      bus(1'b1, pad_ctl_pkg::OFS_GPIO_OUT, ~r);
      settle(2);
      check({pad_pullup, pad_oe, pad_out}, r[23:0]);
      pad_in <= r[7:0];
      settle(5);
      check(pin_value, r[7:0]);
      bus(1'b1, pad_ctl_pkg::OFS_STANDBY_MODE_CONTROL, 32'h0000_0001);
      settle(2);
      check({pad_oe, pad_pullup, pin_value}, 32'h0000_0000);
      $display("test standby done");
      cpu_state <= pad_ctl_pkg::CPU_RUN;
      bus(1'b1, pad_ctl_pkg::OFS_FUNC_SEL, fill(pad_ctl_pkg::FN_ANALOG));
      settle(5);
      check({analog_en, pad_oe, pad_pullup, pin_value}, 32'hFF00_0000);
      $display("test analog done");
      // USB pins follow the controller in run and go off in low power
      r = $random(seed);
      usb_out <= r[7:0];
      usb_oe <= r[15:8];
      pad_in <= r[23:16];
      bus(1'b1, pad_ctl_pkg::OFS_FUNC_SEL, fill(pad_ctl_pkg::FN_USB));
      settle(3);
      check({pad_pullup, pad_oe, pad_out}, {8'h00, r[15:0]});
      cpu_state <= pad_ctl_pkg::CPU_STOP;
      settle(2);
      check({pad_oe, pad_pullup, pin_value}, 32'h0000_0000);
      // Wake-up pins keep their input open in deep standby
      bus(1'b1, pad_ctl_pkg::OFS_FUNC_SEL, fill(pad_ctl_pkg::FN_WAKEUP));
      cpu_state <= pad_ctl_pkg::CPU_DEEP;
      settle(2);
      check({pad_oe, pin_value}, {8'h00, r[23:16]});
      bus(1'b0, pad_ctl_pkg::OFS_STANDBY_MODE_CONTROL, 32'h0000_0000);
      check(rd, 32'h0000_0003);
      // Pin reset turns the debug pull-up on; dedicated pins follow their levels
      bus(1'b1, pad_ctl_pkg::OFS_FUNC_SEL, fill(pad_ctl_pkg::FN_DEBUG));
      cpu_state <= pad_ctl_pkg::CPU_PIN_RESET;
      ext_rst_pin <= r[24];
      boot_pin <= r[25];
      settle(4);
      check({pad_oe, pad_pullup}, 32'h0000_00FF);
      check({bml, erl}, r[25:24]);
      $display("test usb wake debug done");
      close_out();
   end
endmodule : pad_ctl_tb
